// ===== src/fpq_bus_cycle.v
`timescale 1ns/1ps
`default_nettype none

module fpq_bus_cycle (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        clkEn,
  input  wire        start,
  input  wire        isWrite,
  input  wire [21:0] addr,
  input  wire [15:0] wdata,
  input  wire [15:0] flashDqIn,
  output reg         done_r,
  output reg  [15:0] rdata_r,
  output reg         flashCeN_r,
  output reg         flashOeN_r,
  output reg         flashWeN_r,
  output reg  [21:0] flashAddr_r,
  output reg  [15:0] flashDqOut_r,
  output reg         flashDqOe_r
);
`include "fpq_map.vh"

  // Counts stay 32 bits here and are cut to the counter width on purpose
  localparam [31:0] WR_CYC32 = `FPQ_WR_CYC;
  localparam [31:0] RD_CYC32 = `FPQ_RD_CYC;

  reg       active_r;
  reg [7:0] cnt_r;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_r       <= 1'b0;
      rdata_r      <= 16'h0000;
      flashCeN_r   <= 1'b1;
      flashOeN_r   <= 1'b1;
      flashWeN_r   <= 1'b1;
      flashAddr_r  <= 22'h000000;
      flashDqOut_r <= 16'h0000;
      flashDqOe_r  <= 1'b0;
      active_r     <= 1'b0;
      cnt_r        <= 8'h00;
    end else if (clkEn) begin
      done_r <= 1'b0;
      if (!active_r && start) begin
        active_r     <= 1'b1;
        flashAddr_r  <= addr;
        flashCeN_r   <= 1'b0;
        flashOeN_r   <= isWrite;
        flashWeN_r   <= ~isWrite;
        flashDqOut_r <= wdata;
        flashDqOe_r  <= isWrite;
        cnt_r        <= isWrite ? WR_CYC32[7:0] : RD_CYC32[7:0];
      end else if (active_r) begin
        if (cnt_r > 8'h01) begin
          cnt_r <= cnt_r - 8'h01;
        end else begin
          // Data is sampled while OE is still low, then strobes rise
          if (!flashOeN_r) begin
            rdata_r <= flashDqIn;
          end
          flashCeN_r  <= 1'b1;
          flashOeN_r  <= 1'b1;
          flashWeN_r  <= 1'b1;
          flashDqOe_r <= 1'b0;
          active_r    <= 1'b0;
          done_r      <= 1'b1;
        end
      end
    end
  end

endmodule // fpq_bus_cycle

`default_nettype wire

// ===== src/fpq_host.v
// Function
// - Host raises address pin nine to the elevated voltage for that method.
// - Host may enter identification mode by command writes, no high voltage.
// - Group status read: group on top bits, A1 high; 01 protected, 00 not.
// - Protect and unprotect raise only the reset pin voltage.
// - Unprotect refused until every group is known protected.
`timescale 1ns/1ps
`default_nettype none

module fpq_host #(
  parameter [21:0] UNLOCK_ADDR0 = 22'h000000,
  parameter [21:0] UNLOCK_ADDR1 = 22'h000000,
  parameter [21:0] UNLOCK_ADDR2 = 22'h000000,
  parameter [15:0] UNLOCK_DATA0 = 16'h0000,
  parameter [15:0] UNLOCK_DATA1 = 16'h0000,
  parameter [15:0] ID_CMD_DATA  = 16'h0000,
  parameter [15:0] EXIT_DATA    = 16'h0000,
  parameter [15:0] PROT_DATA    = 16'h0000
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        clkEn,
  input  wire        cmdValid,
  input  wire [2:0]  cmdOp,
  input  wire [2:0]  cmdIdSel,
  input  wire [4:0]  cmdGroup,
  input  wire        wpLow,
  output reg         cmdReady_r,
  output reg         rspValid_r,
  output reg         rspErr_r,
  output reg  [7:0]  rspData_r,
  output reg  [31:0] groupMap_r,
  output reg         tempOn_r,
  output wire        flashCeN,
  output wire        flashOeN,
  output wire        flashWeN,
  output wire [21:0] flashAddr,
  output wire [15:0] flashDqOut,
  output wire        flashDqOe,
  input  wire [15:0] flashDqIn,
  output reg         idVoltageEn_r,
  output reg         resetVoltageEn_r,
  output reg         flashResetN_r,
  output reg         flashWpN_r
);
`include "fpq_map.vh"

  localparam [4:0] S_IDLE  = 5'b00001;
  localparam [4:0] S_SETUP = 5'b00010;
  localparam [4:0] S_CYC   = 5'b00100;
  localparam [4:0] S_LAUNCH = 5'b01000;
  localparam [4:0] S_DONE  = 5'b10000;
  localparam [31:0] HV_CYC32 = `FPQ_HV_CYC;
  reg [4:0]  state_r;
  reg [2:0]  op_r;
  reg [2:0]  idSel_r;
  reg [4:0]  grp_r;
  reg [1:0]  step_r;
  reg [9:0]  cnt_r;
  reg        busStart_r;
  reg        busWr_r;
  reg [21:0] busAddr_r;
  reg [15:0] busData_r;
  wire       busDone;
  wire [15:0] busRdata;

  // Address that selects one identification code
  function [21:0] idAddr;
    input [2:0] sel;
    input [4:0] grp;
    begin
      idAddr = 22'h000000;
      case (sel)
        `FPQ_ID_MAKER: idAddr[3:0] = 4'h0;
        `FPQ_ID_DEV1:  idAddr[3:0] = 4'h1;
        `FPQ_ID_DEV2:  idAddr[3:0] = 4'he;
        `FPQ_ID_DEV3:  idAddr[3:0] = 4'hf;
        `FPQ_ID_GROUP: begin
          idAddr[`FPQ_A_GRP_HI:`FPQ_A_GRP_LO] = grp;
          idAddr[3:0] = 4'h2;
        end
        `FPQ_ID_SECURED: idAddr[3:0] = 4'h3;
        default: idAddr[3:0] = 4'h0;
      endcase
    end
  endfunction

  function [21:0] unlockAddr;
    input [1:0] s;
    begin
      case (s)
        2'h0:    unlockAddr = UNLOCK_ADDR0;
        2'h1:    unlockAddr = UNLOCK_ADDR1;
        default: unlockAddr = UNLOCK_ADDR2;
      endcase
    end
  endfunction

  function [15:0] unlockData;
    input [1:0] s;
    begin
      case (s)
        2'h0:    unlockData = UNLOCK_DATA0;
        2'h1:    unlockData = UNLOCK_DATA1;
        default: unlockData = ID_CMD_DATA;
      endcase
    end
  endfunction

  fpq_bus_cycle u_bus (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .clkEn        (clkEn),
    .start        (busStart_r),
    .isWrite      (busWr_r),
    .addr         (busAddr_r),
    .wdata        (busData_r),
    .flashDqIn    (flashDqIn),
    .done_r       (busDone),
    .rdata_r      (busRdata),
    .flashCeN_r   (flashCeN),
    .flashOeN_r   (flashOeN),
    .flashWeN_r   (flashWeN),
    .flashAddr_r  (flashAddr),
    .flashDqOut_r (flashDqOut),
    .flashDqOe_r  (flashDqOe)
  );

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r          <= S_IDLE;
      op_r             <= 3'h0;
      idSel_r          <= 3'h0;
      grp_r            <= 5'h00;
      step_r           <= 2'h0;
      cnt_r            <= 10'h000;
      busStart_r       <= 1'b0;
      busWr_r          <= 1'b0;
      busAddr_r        <= 22'h000000;
      busData_r        <= 16'h0000;
      cmdReady_r       <= 1'b0;
      rspValid_r       <= 1'b0;
      rspErr_r         <= 1'b0;
      rspData_r        <= 8'h00;
      groupMap_r       <= `FPQ_MAP_RST;
      tempOn_r         <= 1'b0;
      idVoltageEn_r    <= 1'b0;
      resetVoltageEn_r <= 1'b0;
      flashResetN_r    <= 1'b1;
      flashWpN_r       <= 1'b1;
    end else if (clkEn) begin
      busStart_r <= 1'b0;
      rspValid_r <= 1'b0;
      flashWpN_r <= ~wpLow;
      case (state_r)
        S_IDLE: begin
          cmdReady_r <= 1'b1;
          if (cmdValid) begin
            cmdReady_r <= 1'b0;
            op_r       <= cmdOp;
            idSel_r    <= cmdIdSel;
            grp_r      <= cmdGroup;
            step_r     <= 2'h0;
            rspErr_r   <= 1'b0;
            rspData_r  <= 8'h00;
            cnt_r      <= HV_CYC32[9:0];
            state_r    <= S_SETUP;
            case (cmdOp)
              `FPQ_OP_READ_HV: begin
                idVoltageEn_r <= 1'b1;
              end
              `FPQ_OP_SCAN: begin
                idVoltageEn_r <= 1'b1;
                grp_r         <= 5'h00;
                idSel_r       <= `FPQ_ID_GROUP;
              end
              `FPQ_OP_PROTECT: begin
                resetVoltageEn_r <= 1'b1;
              end
              `FPQ_OP_UNPROT: begin
                if (groupMap_r != 32'hffffffff) begin
                  rspErr_r <= 1'b1;
                  state_r  <= S_DONE;
                end else begin
                  resetVoltageEn_r <= 1'b1;
                end
              end
              `FPQ_OP_TEMP_ON: begin
                tempOn_r         <= 1'b1;
                resetVoltageEn_r <= 1'b1;
                state_r          <= S_DONE;
              end
              `FPQ_OP_TEMP_OFF: begin
                tempOn_r         <= 1'b0;
                resetVoltageEn_r <= 1'b0;
                state_r          <= S_DONE;
              end
              // Command modes need no high voltage settle time
              default: cnt_r <= 10'h001;
            endcase
          end
        end
        S_SETUP: begin
          if (cnt_r > 10'h001) begin
            cnt_r <= cnt_r - 10'h001;
          end else begin
            state_r <= S_LAUNCH;
          end
        end
        S_LAUNCH: begin
          busStart_r <= 1'b1;
          state_r    <= S_CYC;
          busWr_r    <= 1'b1;
          busData_r  <= 16'h0000;
          busAddr_r  <= 22'h000000;
          case (op_r)
            `FPQ_OP_READ_SW: begin
              if (step_r == 2'h3) begin
                busWr_r   <= 1'b0;
                busAddr_r <= idAddr(idSel_r, grp_r);
              end else begin
                busAddr_r <= unlockAddr(step_r);
                busData_r <= unlockData(step_r);
              end
            end
            `FPQ_OP_EXIT: busData_r <= EXIT_DATA;
            `FPQ_OP_PROTECT, `FPQ_OP_UNPROT: begin
              busAddr_r[`FPQ_A_GRP_HI:`FPQ_A_GRP_LO] <= grp_r;
              busAddr_r[`FPQ_A_BIT1] <= 1'b1;
              busAddr_r[`FPQ_A_BIT6] <= (op_r == `FPQ_OP_UNPROT);
              busData_r <= PROT_DATA;
            end
            default: begin
              busWr_r   <= 1'b0;
              busAddr_r <= idAddr(idSel_r, grp_r);
            end
          endcase
        end
        S_CYC: begin
          if (busDone) begin
            state_r <= S_DONE;
            rspData_r <= busRdata[7:0];
            case (op_r)
              `FPQ_OP_READ_SW: begin
                if (step_r != 2'h3) begin
                  step_r  <= step_r + 2'h1;
                  state_r <= S_LAUNCH;
                end
              end
              `FPQ_OP_SCAN: begin
                groupMap_r[grp_r] <= busRdata[0];
                if (grp_r != 5'h1f) begin
                  grp_r   <= grp_r + 5'h01;
                  state_r <= S_LAUNCH;
                end
              end
              `FPQ_OP_PROTECT: groupMap_r[grp_r] <= 1'b1;
              // Unprotect clears every group at once
              `FPQ_OP_UNPROT: groupMap_r <= `FPQ_MAP_RST;
              default: ;
            endcase
          end
        end
        S_DONE: begin
          rspValid_r       <= 1'b1;
          idVoltageEn_r    <= 1'b0;
          resetVoltageEn_r <= tempOn_r;
          cmdReady_r       <= 1'b1;
          state_r          <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule // fpq_host

`default_nettype wire

// ===== src/fpq_map.vh
`ifndef FPQ_MAP_VH
`define FPQ_MAP_VH

// Clock and bus timing, nanoseconds as given, cycles derived
`define FPQ_CLK_NS     10
`define FPQ_T_RD_NS    100
`define FPQ_T_WR_NS    50
`define FPQ_T_HV_NS    1000
`define FPQ_CYC(ns)    (((ns) + `FPQ_CLK_NS - 1) / `FPQ_CLK_NS)
`define FPQ_RD_CYC     `FPQ_CYC(`FPQ_T_RD_NS)
`define FPQ_WR_CYC     `FPQ_CYC(`FPQ_T_WR_NS)
`define FPQ_HV_CYC     `FPQ_CYC(`FPQ_T_HV_NS)

// User operations
`define FPQ_OP_READ_HV 3'h0
`define FPQ_OP_READ_SW 3'h1
`define FPQ_OP_EXIT    3'h2
`define FPQ_OP_PROTECT 3'h3
`define FPQ_OP_UNPROT  3'h4
`define FPQ_OP_TEMP_ON 3'h5
`define FPQ_OP_TEMP_OFF 3'h6
`define FPQ_OP_SCAN    3'h7

// Identification code selectors
`define FPQ_ID_MAKER   3'h0
`define FPQ_ID_DEV1    3'h1
`define FPQ_ID_DEV2    3'h2
`define FPQ_ID_DEV3    3'h3
`define FPQ_ID_GROUP   3'h4
`define FPQ_ID_SECURED 3'h5

// Address field positions
`define FPQ_A_GRP_HI   21
`define FPQ_A_GRP_LO   17
`define FPQ_A_BIT6     6
`define FPQ_A_BIT1     1
`define FPQ_NGROUPS    32
`define FPQ_MAP_RST    32'h00000000

`endif

// ===== verification/fpq_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpq_flash_model #(
  parameter [15:0] MAKER = 16'h0000,
  parameter [15:0] DEV1  = 16'h0000,
  parameter [15:0] DEV2  = 16'h0000,
  parameter [15:0] DEV3  = 16'h0000,
  parameter [7:0]  SEC   = 8'h18,
  parameter [15:0] IDC   = 16'h0000,
  parameter [15:0] EXC   = 16'h0000
) (
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] din,
  input  wire logic        dinOe,
  input  wire logic        idHv,
  input  wire logic        rstHv,
  input  wire logic        wpN,
  output wire logic [15:0] dout
);
  logic [31:0] prot = 32'h0;
  logic        swId = 1'b0;
  logic [15:0] cur;
  logic [15:0] last = 16'h0;
  wire         rd = !ceN && !oeN && weN;
  wire         blk = prot[addr[21:17]] && !rstHv || &addr[21:15] && !wpN;
  always @* begin
    cur = addr[15:0] ^ 16'hc3c3;
    if ((idHv || swId) && !addr[6])
      case (addr[3:0])
        4'h0: cur = MAKER;
        4'h1: cur = DEV1;
        4'he: cur = DEV2;
        4'hf: cur = DEV3;
        4'h2: cur = {8'ha5, 7'h0, prot[addr[21:17]]};
        4'h3: cur = {8'ha5, SEC};
        default: cur = 16'h0;
      endcase
    if (rd)
      last = cur;
  end
  // Released bus shows the inverse so a stale sample cannot pass
  assign dout = rd ? cur : ~last;
  // Command and protect writes
  // Chip select rises and data enable falls with write enable, so they are
  // already released here; address and data stay put and carry the write
  always @(posedge weN) begin
    if (1'b1) begin
      if (rstHv && addr[1])
        prot <= addr[6] ? 32'h0 : prot | (32'h1 << addr[21:17]);
      else if (din == IDC)
        swId <= 1'b1;
      else if (din == EXC)
        swId <= 1'b0;
    end
  end
endmodule // fpq_flash_model
`default_nettype wire

// ===== verification/fpq_host_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpq_map.vh"
module fpq_host_assertions (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        cmdValid,
  input wire logic [2:0]  cmdOp,
  input wire logic        wpLow,
  input wire logic        cmdReady_r,
  input wire logic        rspValid_r,
  input wire logic        rspErr_r,
  input wire logic [31:0] groupMap_r,
  input wire logic        flashCeN,
  input wire logic        flashOeN,
  input wire logic        flashWeN,
  input wire logic [21:0] flashAddr,
  input wire logic        idVoltageEn_r,
  input wire logic        resetVoltageEn_r,
  input wire logic        flashWpN_r
);
  wire take = cmdValid && cmdReady_r;
  wire badUnp = take && cmdOp == `FPQ_OP_UNPROT && ~&groupMap_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_read_strobes: assert property (
    !flashOeN |-> !flashCeN && flashWeN) else $error("read strobes");
  chk_hv_addr: assert property (
    idVoltageEn_r && !flashOeN |-> !flashAddr[6]) else $error("hv addr");
  chk_write_no_hv: assert property (
    !flashWeN |-> !idVoltageEn_r) else $error("write with hv");
  chk_prot_write: assert property (
    !flashWeN && resetVoltageEn_r |-> flashAddr[1]) else $error("prot addr");
  chk_unprot_refuse: assert property (
    badUnp |=> ##1 rspValid_r && rspErr_r) else $error("unprot refuse");
  chk_unprot_quiet: assert property (
    badUnp |-> ##1 flashWeN[*2]) else $error("unprot wrote");
  chk_temp_on: assert property (
    take && cmdOp == `FPQ_OP_TEMP_ON |=> ##1 rspValid_r && resetVoltageEn_r)
    else $error("temp on");
  chk_temp_off: assert property (
    take && cmdOp == `FPQ_OP_TEMP_OFF |=> ##1 rspValid_r && !resetVoltageEn_r)
    else $error("temp off");
  chk_wp_follow: assert property (
    1'b1 |=> flashWpN_r == !$past(wpLow)) else $error("wp pin");
endmodule // fpq_host_assertions
bind fpq_host fpq_host_assertions u_chk (.clk(clk), .sys_rst(sys_rst),
  .cmdValid(cmdValid), .cmdOp(cmdOp), .wpLow(wpLow),
  .cmdReady_r(cmdReady_r), .rspValid_r(rspValid_r), .rspErr_r(rspErr_r),
  .groupMap_r(groupMap_r), .flashCeN(flashCeN), .flashOeN(flashOeN),
  .flashWeN(flashWeN), .flashAddr(flashAddr), .idVoltageEn_r(idVoltageEn_r),
  .resetVoltageEn_r(resetVoltageEn_r), .flashWpN_r(flashWpN_r));
`default_nettype wire

// ===== verification/fpq_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpq_map.vh"
module fpq_host_tb;
  // Identification codes are arbitrary
  localparam [15:0] MK  = 16'h3c5a;
  localparam [15:0] D1  = 16'h4b11;
  localparam [15:0] D2  = 16'h4b22;
  localparam [15:0] D3  = 16'h4b33;
  localparam [7:0]  SC  = 8'h18;
  localparam [15:0] IDC = 16'h00c3;
  localparam [15:0] EXC = 16'h00d4;
  logic        clk, sys_rst, cmdValid, wpLow, hvSeen;
  logic [2:0]  cmdOp, cmdIdSel;
  logic [4:0]  cmdGroup;
  wire         cmdReady_r, rspValid_r, rspErr_r, tempOn_r, flashCeN;
  wire         flashOeN, flashWeN, flashDqOe, idVoltageEn_r, flashWpN_r;
  wire         resetVoltageEn_r, flashResetN_r;
  wire  [7:0]  rspData_r;
  wire  [31:0] groupMap_r;
  wire  [21:0] flashAddr;
  wire  [15:0] flashDqOut, flashDqIn;
  integer      errors, checks_done, i;
  fpq_host #(.ID_CMD_DATA(IDC), .EXIT_DATA(EXC)) DUT (
    .clk(clk), .sys_rst(sys_rst), .clkEn(1'b1), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdIdSel(cmdIdSel), .cmdGroup(cmdGroup), .wpLow(wpLow),
    .cmdReady_r(cmdReady_r), .rspValid_r(rspValid_r), .rspErr_r(rspErr_r),
    .rspData_r(rspData_r), .groupMap_r(groupMap_r), .tempOn_r(tempOn_r),
    .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
    .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
    .flashDqIn(flashDqIn), .idVoltageEn_r(idVoltageEn_r),
    .resetVoltageEn_r(resetVoltageEn_r), .flashResetN_r(flashResetN_r),
    .flashWpN_r(flashWpN_r));
  fpq_flash_model #(.MAKER(MK), .DEV1(D1), .DEV2(D2), .DEV3(D3), .SEC(SC),
    .IDC(IDC), .EXC(EXC)) u_flash (.ceN(flashCeN), .oeN(flashOeN),
    .weN(flashWeN), .addr(flashAddr), .din(flashDqOut), .dinOe(flashDqOe),
    .idHv(idVoltageEn_r), .rstHv(resetVoltageEn_r), .wpN(flashWpN_r),
    .dout(flashDqIn));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (idVoltageEn_r === 1'b1) hvSeen <= 1'b1;
  task check(input logic [31:0] seen, input logic [31:0] exp,
             input string what);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task run(input logic [2:0] op, input logic [2:0] sel,
           input logic [4:0] grp);
    integer n;
    begin
      n = 0;
      @(negedge clk);
      while (cmdReady_r !== 1'b1 && n < 50) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n >= 50) begin
        errors = errors + 1;
        end_of_test;
      end
      cmdOp = op;
      cmdIdSel = sel;
      cmdGroup = grp;
      cmdValid = 1'b1;
      @(negedge clk);
      cmdValid = 1'b0;
      while (rspValid_r !== 1'b1 && n < 6000) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n >= 6000) begin
        errors = errors + 1;
        end_of_test;
      end
    end
  endtask
  function automatic logic [7:0] idExp(input logic [2:0] s);
    case (s)
      `FPQ_ID_MAKER: idExp = MK[7:0];
      `FPQ_ID_DEV1: idExp = D1[7:0];
      `FPQ_ID_DEV2: idExp = D2[7:0];
      `FPQ_ID_DEV3: idExp = D3[7:0];
      `FPQ_ID_SECURED: idExp = SC;
      default: idExp = 8'h00;
    endcase
  endfunction
  task t_reset;
    begin
      check(groupMap_r, 32'h0, "map");
      check(flashResetN_r, 1'b1, "reset pin");
      run(`FPQ_OP_SCAN, 3'h0, 5'h0);
      check(groupMap_r, 32'h0, "scan map");
    end
  endtask
  task t_id;
    begin
      hvSeen = 1'b0;
      for (i = 0; i < 6; i = i + 1) begin
        run(`FPQ_OP_READ_HV, i[2:0], 5'h09);
        check(rspData_r, idExp(i[2:0]), "hv id");
      end
      check(hvSeen, 1'b1, "hv raised");
      hvSeen = 1'b0;
      run(`FPQ_OP_READ_SW, `FPQ_ID_MAKER, 5'h0);
      check(rspData_r, MK[7:0], "sw maker");
      run(`FPQ_OP_READ_SW, `FPQ_ID_SECURED, 5'h0);
      check(rspData_r, SC, "sw secured");
      check(hvSeen, 1'b0, "sw no hv");
      run(`FPQ_OP_EXIT, 3'h0, 5'h0);
    end
  endtask
  task t_protect;
    begin
      run(`FPQ_OP_PROTECT, 3'h0, 5'h05);
      check(groupMap_r, 32'h20, "map one");
      run(`FPQ_OP_READ_HV, `FPQ_ID_GROUP, 5'h05);
      check(rspData_r, 8'h01, "grp5");
      run(`FPQ_OP_READ_HV, `FPQ_ID_GROUP, 5'h04);
      check(rspData_r, 8'h00, "grp4");
      run(`FPQ_OP_UNPROT, 3'h0, 5'h0);
      check(rspErr_r, 1'b1, "refused");
      check(groupMap_r, 32'h20, "map kept");
    end
  endtask
  task t_all;
    begin
      hvSeen = 1'b0;
      for (i = 0; i < 32; i = i + 1)
        run(`FPQ_OP_PROTECT, 3'h0, i[4:0]);
      check(groupMap_r, 32'hffffffff, "map all");
      check(hvSeen, 1'b0, "prot no hv");
      wpLow = 1'b1;
      run(`FPQ_OP_TEMP_ON, 3'h0, 5'h0);
      check(resetVoltageEn_r, 1'b1, "temp pin");
      check(tempOn_r, 1'b1, "temp on");
      check(flashWpN_r, 1'b0, "wp low");
      run(`FPQ_OP_TEMP_OFF, 3'h0, 5'h0);
      check(resetVoltageEn_r, 1'b0, "temp off");
      wpLow = 1'b0;
      run(`FPQ_OP_SCAN, 3'h0, 5'h0);
      check(groupMap_r, 32'hffffffff, "map back");
      check(flashWpN_r, 1'b1, "wp high");
      run(`FPQ_OP_UNPROT, 3'h0, 5'h0);
      check(rspErr_r, 1'b0, "unprot ok");
      run(`FPQ_OP_SCAN, 3'h0, 5'h0);
      check(groupMap_r, 32'h0, "map clear");
    end
  endtask
  initial begin
    errors = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    cmdValid = 1'b0;
    cmdOp = 3'h0;
    cmdIdSel = 3'h0;
    cmdGroup = 5'h0;
    wpLow = 1'b0;
    hvSeen = 1'b0;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    t_reset;
    t_id;
    t_protect;
    t_all;
    end_of_test;
  end
endmodule // fpq_host_tb
`default_nettype wire
